// ---- verilog/wheel_decoder_pkg.sv ----
// Constants, register map and state types of the scroll wheel phase decoder
package wheel_decoder_pkg;

	// Clocking
	localparam int unsigned SYS_CLK_HZ = 20_000_000;
	localparam int unsigned SLOW_CLK_HZ = 32_768;
	localparam int unsigned SLOW_DIV_CYCLES = SYS_CLK_HZ / SLOW_CLK_HZ;
	localparam int unsigned SLOW_DIV_W = 10;

	// Debounce: window is 2^(n+1)*3 slow periods, sampled every 2^n
	localparam int unsigned DEB_WINDOW_FACTOR = 3;
	localparam int unsigned DEB_SAMPLES = 2 * DEB_WINDOW_FACTOR;
	localparam int unsigned DEB_CNT_W = 3;
	localparam int unsigned SAMP_CNT_W = 7;

	// Register offsets
	localparam logic [7:0] OFS_EDGE_COUNT_SNAPSHOT = 8'hd0;
	localparam logic [7:0] OFS_DEBOUNCE_POLARITY_SHUTTLE_CONFIG = 8'hd1;
	localparam logic [7:0] OFS_PHASE_A_PIN_SELECT = 8'hd2;
	localparam logic [7:0] OFS_PHASE_B_PIN_SELECT = 8'hd3;
	localparam logic [7:0] OFS_SPARE_CONTROL = 8'hd6;
	localparam logic [7:0] OFS_EDGE_MODE_SELECT = 8'hd7;
	localparam logic [7:0] OFS_COUNT_LOAD_TRIGGER = 8'hd8;

	// Field positions
	localparam int unsigned FLD_FILTER_LSB = 0;
	localparam int unsigned FLD_FILTER_W = 3;
	localparam int unsigned FLD_POLARITY = 4;
	localparam int unsigned FLD_SHUTTLE = 5;
	localparam int unsigned FLD_PIN_SEL_W = 3;
	localparam int unsigned FLD_DOUBLE = 0;
	localparam int unsigned FLD_LOAD = 0;
	localparam int unsigned FLD_SPARE = 0;

	// Values after reset
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [2:0] RST_PHASE_A_SEL = 3'h0;
	localparam logic [2:0] RST_PHASE_B_SEL = 3'h1;
	localparam logic [7:0] RST_COUNT = 8'h00;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [DEB_CNT_W-1:0] run;
		logic level;
	} filter_state_s;

	typedef struct packed {
		logic a;
		logic b;
		logic last_b;
		logic pend;
		logic dir;
		logic step;
		logic up;
	} stepper_state_s;

	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [SLOW_DIV_W-1:0] div_cnt;
		logic slow_tick;
		logic [SAMP_CNT_W-1:0] samp_cnt;
		logic samp_en;
		logic phase_a_raw;
		logic phase_b_raw;
		logic [7:0] count;
		logic [7:0] snapshot;
		logic [FLD_FILTER_W-1:0] filter_n;
		logic polarity;
		logic shuttle;
		logic [FLD_PIN_SEL_W-1:0] sel_a;
		logic [FLD_PIN_SEL_W-1:0] sel_b;
		logic spare;
		logic dbl;
		logic [7:0] rdata;
	} top_state_s;

endpackage

// ---- verilog/phase_filter.sv ----
// Debounce filter for one wheel phase, stepped by the sample enable
`timescale 1ns/100ps
module phase_filter #(
	parameter int unsigned SAMPLES = wheel_decoder_pkg::DEB_SAMPLES
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic samp_en_i,
	input wire logic raw_i,
	output logic level_o
);

	localparam logic [wheel_decoder_pkg::DEB_CNT_W-1:0] LAST_RUN =
		wheel_decoder_pkg::DEB_CNT_W'(SAMPLES - 1);

	wheel_decoder_pkg::filter_state_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (samp_en_i) begin
			if (raw_i == s_q.level) begin
				// Any glitch back to the held level restarts the window
				s_d.run = '0;
			end else if (s_q.run == LAST_RUN) begin
				// New level held for the whole window
				s_d.level = raw_i;
				s_d.run = '0;
			end else begin
				s_d.run = s_q.run + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.level;

endmodule

// ---- verilog/edge_stepper.sv ----
// Turns filtered phase levels into count steps with a direction
`timescale 1ns/100ps
module edge_stepper (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic phase_a_i,
	input wire logic phase_b_i,
	input wire logic dbl_i,
	input wire logic shuttle_i,
	output logic step_o,
	output logic up_o
);

	wheel_decoder_pkg::stepper_state_s s_q, s_d;
	logic a_chg, b_chg;

	assign a_chg = phase_a_i ^ s_q.a;
	assign b_chg = phase_b_i ^ s_q.b;

	always_comb begin
		s_d = s_q;
		s_d.a = phase_a_i;
		s_d.b = phase_b_i;
		s_d.step = 1'b0;
		s_d.up = s_q.up;
		// Leaving shuttle mode drops a half-seen pulse pair
		s_d.pend = s_q.pend && shuttle_i;
		if (shuttle_i) begin
			// Pulses never overlap: pulses pair up, the second one of a pair
			// gives the step, so a steady turn counts every pair the same way
			if (a_chg && phase_a_i && !b_chg) begin
				s_d.step = s_q.pend && s_q.last_b;
				s_d.up = 1'b0;
				s_d.dir = 1'b0;
				s_d.pend = !(s_q.pend && s_q.last_b);
				s_d.last_b = 1'b0;
			end else if (b_chg && phase_b_i && !a_chg) begin
				s_d.step = s_q.pend && !s_q.last_b;
				s_d.up = 1'b1;
				s_d.dir = 1'b1;
				s_d.pend = !(s_q.pend && !s_q.last_b);
				s_d.last_b = 1'b1;
			end else if ((a_chg ^ b_chg) && dbl_i) begin
				// Falling edge of the last pulse seen, counted or not, stepped in its direction
				s_d.step = 1'b1;
				s_d.up = s_q.dir;
			end
		end else if (a_chg && !b_chg) begin
			// Both phases moving at once is illegal and dropped
			s_d.step = dbl_i || (phase_a_i == phase_b_i);
			s_d.up = (phase_a_i != phase_b_i);
		end else if (b_chg && !a_chg) begin
			s_d.step = dbl_i || (phase_a_i == phase_b_i);
			s_d.up = (phase_a_i == phase_b_i);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign step_o = s_q.step;
	assign up_o = s_q.up;

endmodule

// ---- verilog/wheel_phase_decoder.sv ----
// Scroll wheel phase decoder: pin select, debounce, edge count, registers
// Summary of operation
// - Filter field sets debounce window; shorter disturbances never change the count.
// - Polarity bit gives idle level: 0 rests low, 1 rests high.
// - Shuttle bit on lets non-overlapping phase pulses still decode rotation.
// - Sampling, filtering and counting run off the 32 kHz rate.
// - Levels shorter than 2^(n+1)*3 slow periods are treated as jitter.
// - Phases are sampled every 2^n slow periods.
// - Snapshot register shows counted edges; reading it clears it.
// - Per-phase 3-bit pin selector; A resets to 0, B to 1.
// - Edge mode bit 0 set selects double accuracy, clear selects common.
// - Writing 1 to load bit 0 copies internal counter into snapshot.
// - Common mode steps once after same edge kind seen on both phases.
// - Double mode steps on every edge, two counts per detent, with shuttle off.
// - Internal counter is hidden; snapshot changes only on load request or when it is read.
// - Block reset from the system reset register clears the internal counter.
`timescale 1ns/100ps
module wheel_phase_decoder #(
	parameter int unsigned SLOW_DIV = wheel_decoder_pkg::SLOW_DIV_CYCLES,
	parameter int unsigned DEB_SAMPLES = wheel_decoder_pkg::DEB_SAMPLES
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic block_reset_i,
	input wire wheel_decoder_pkg::reg_req_s reg_req_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] port_pins_i
);

	localparam logic [wheel_decoder_pkg::SLOW_DIV_W-1:0] DIV_LAST =
		wheel_decoder_pkg::SLOW_DIV_W'(SLOW_DIV - 1);

	wheel_decoder_pkg::top_state_s s_q, s_d;

	logic phase_a_filt;
	logic phase_b_filt;
	logic step;
	logic step_up;
	logic [wheel_decoder_pkg::SAMP_CNT_W-1:0] samp_last;
	logic [7:0] cfg_view;

	// Sample period in slow ticks minus one, i.e. 2^n - 1
	assign samp_last = wheel_decoder_pkg::SAMP_CNT_W'((8'h01 << s_q.filter_n) - 8'h01);

	assign cfg_view = {
		2'b00,
		s_q.shuttle,
		s_q.polarity,
		1'b0,
		s_q.filter_n
	};

	phase_filter #(
		.SAMPLES(DEB_SAMPLES)
	) u_filter_a (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.samp_en_i(s_q.samp_en),
		.raw_i(s_q.phase_a_raw),
		.level_o(phase_a_filt)
	);

	phase_filter #(
		.SAMPLES(DEB_SAMPLES)
	) u_filter_b (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.samp_en_i(s_q.samp_en),
		.raw_i(s_q.phase_b_raw),
		.level_o(phase_b_filt)
	);

	edge_stepper u_stepper (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.phase_a_i(phase_a_filt),
		.phase_b_i(phase_b_filt),
		.dbl_i(s_q.dbl),
		.shuttle_i(s_q.shuttle),
		.step_o(step),
		.up_o(step_up)
	);

	always_comb begin
		s_d = s_q;

		// Pins are asynchronous to the system clock
		s_d.sync1 = port_pins_i;
		s_d.sync2 = s_q.sync1;

		// Slow tick stands in for the 32 kHz clock, keeps one clock tree
		s_d.slow_tick = 1'b0;
		if (s_q.div_cnt == DIV_LAST) begin
			s_d.div_cnt = '0;
			s_d.slow_tick = 1'b1;
		end else begin
			s_d.div_cnt = s_q.div_cnt + 1'b1;
		end

		// Sample enable every 2^n slow ticks
		s_d.samp_en = 1'b0;
		if (s_q.slow_tick) begin
			if (s_q.samp_cnt >= samp_last) begin
				s_d.samp_cnt = '0;
				s_d.samp_en = 1'b1;
			end else begin
				s_d.samp_cnt = s_q.samp_cnt + 1'b1;
			end
		end

		// Pin select, then fold idle level to low for the filters
		s_d.phase_a_raw = s_q.sync2[s_q.sel_a] ^ s_q.polarity;
		s_d.phase_b_raw = s_q.sync2[s_q.sel_b] ^ s_q.polarity;

		// Internal counter, wraps modulo 256
		if (block_reset_i) begin
			s_d.count = wheel_decoder_pkg::RST_COUNT;
		end else if (step) begin
			if (step_up) begin
				s_d.count = s_q.count + 8'h01;
			end else begin
				s_d.count = s_q.count - 8'h01;
			end
		end

		// Register writes
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				wheel_decoder_pkg::OFS_DEBOUNCE_POLARITY_SHUTTLE_CONFIG: begin
					s_d.filter_n = reg_req_i.wdata[wheel_decoder_pkg::FLD_FILTER_LSB +:
						wheel_decoder_pkg::FLD_FILTER_W];
					s_d.polarity = reg_req_i.wdata[wheel_decoder_pkg::FLD_POLARITY];
					s_d.shuttle = reg_req_i.wdata[wheel_decoder_pkg::FLD_SHUTTLE];
				end
				wheel_decoder_pkg::OFS_PHASE_A_PIN_SELECT: begin
					s_d.sel_a = reg_req_i.wdata[wheel_decoder_pkg::FLD_PIN_SEL_W-1:0];
				end
				wheel_decoder_pkg::OFS_PHASE_B_PIN_SELECT: begin
					s_d.sel_b = reg_req_i.wdata[wheel_decoder_pkg::FLD_PIN_SEL_W-1:0];
				end
				wheel_decoder_pkg::OFS_SPARE_CONTROL: begin
					s_d.spare = reg_req_i.wdata[wheel_decoder_pkg::FLD_SPARE];
				end
				wheel_decoder_pkg::OFS_EDGE_MODE_SELECT: begin
					s_d.dbl = reg_req_i.wdata[wheel_decoder_pkg::FLD_DOUBLE];
				end
				wheel_decoder_pkg::OFS_COUNT_LOAD_TRIGGER: begin
					// Only path that copies the count into the snapshot
					if (reg_req_i.wdata[wheel_decoder_pkg::FLD_LOAD]) begin
						s_d.snapshot = s_q.count;
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads, data stand one cycle later
		s_d.rdata = 8'h00;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				wheel_decoder_pkg::OFS_EDGE_COUNT_SNAPSHOT: begin
					s_d.rdata = s_q.snapshot;
					s_d.snapshot = wheel_decoder_pkg::RST_COUNT;
				end
				wheel_decoder_pkg::OFS_DEBOUNCE_POLARITY_SHUTTLE_CONFIG: begin
					s_d.rdata = cfg_view;
				end
				wheel_decoder_pkg::OFS_PHASE_A_PIN_SELECT: begin
					s_d.rdata = {5'h00, s_q.sel_a};
				end
				wheel_decoder_pkg::OFS_PHASE_B_PIN_SELECT: begin
					s_d.rdata = {5'h00, s_q.sel_b};
				end
				wheel_decoder_pkg::OFS_SPARE_CONTROL: begin
					s_d.rdata = {7'h00, s_q.spare};
				end
				wheel_decoder_pkg::OFS_EDGE_MODE_SELECT: begin
					s_d.rdata = {7'h00, s_q.dbl};
				end
				default: begin
					// Load trigger is self-clearing; unmapped reads zero
					s_d.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_q <= '0;
			s_q.filter_n <= wheel_decoder_pkg::RST_CONFIG[2:0];
			s_q.polarity <= wheel_decoder_pkg::RST_CONFIG[wheel_decoder_pkg::FLD_POLARITY];
			s_q.shuttle <= wheel_decoder_pkg::RST_CONFIG[wheel_decoder_pkg::FLD_SHUTTLE];
			s_q.sel_a <= wheel_decoder_pkg::RST_PHASE_A_SEL;
			s_q.sel_b <= wheel_decoder_pkg::RST_PHASE_B_SEL;
			s_q.count <= wheel_decoder_pkg::RST_COUNT;
			s_q.snapshot <= wheel_decoder_pkg::RST_COUNT;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o = s_q.rdata;

endmodule

// ---- testbench/wheel_decoder_checker.sv ----
// Register port assertions of the wheel phase decoder
`timescale 1ns/100ps
module wheel_decoder_checker (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic block_reset_i,
	input wire wheel_decoder_pkg::reg_req_s reg_req_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [7:0] port_pins_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence rd_of(logic [7:0] a);
		reg_req_i.rd && reg_req_i.addr == a;
	endsequence
	sequence wr_of(logic [7:0] a);
		reg_req_i.wr && reg_req_i.addr == a;
	endsequence
	sequence wr_rd(logic [7:0] a);
		wr_of(a) ##1 rd_of(a);
	endsequence
	idle_rdata_zero_a: assert property (!reg_req_i.rd |=> reg_rdata_o == 8'h00)
		else $error("read data outside read");
	read_clears_a: assert property (rd_of(8'hd0) ##1 rd_of(8'hd0) |=> reg_rdata_o == 8'h00)
		else $error("snapshot not cleared");
	unmapped_zero_a: assert property (reg_req_i.rd &&
		!(reg_req_i.addr inside {8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd6, 8'hd7}) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	mode_rw_a: assert property (wr_rd(8'hd7) |=> reg_rdata_o == {7'h00, $past(reg_req_i.wdata[0], 2)})
		else $error("edge mode readback");
	sel_a_rw_a: assert property (wr_rd(8'hd2) |=> reg_rdata_o == {5'h00, $past(reg_req_i.wdata[2:0], 2)})
		else $error("phase a select readback");
	sel_b_rw_a: assert property (wr_rd(8'hd3) |=> reg_rdata_o == {5'h00, $past(reg_req_i.wdata[2:0], 2)})
		else $error("phase b select readback");
	config_rw_a: assert property (wr_rd(8'hd1) |=> reg_rdata_o ==
		{2'b00, $past(reg_req_i.wdata[5:4], 2), 1'b0, $past(reg_req_i.wdata[2:0], 2)})
		else $error("config readback");
	block_clear_a: assert property (block_reset_i ##1 block_reset_i ##0 wr_of(8'hd8) ##1 rd_of(8'hd0)
		|=> reg_rdata_o == 8'h00)
		else $error("block reset left count");
endmodule
bind wheel_phase_decoder wheel_decoder_checker chk_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.block_reset_i(block_reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .port_pins_i(port_pins_i));

// ---- testbench/wheel_encoder_model.sv ----
// Behavioural scroll wheel encoder on the port pins
`timescale 1ns/100ps
module wheel_encoder_model (
	input wire logic sys_clk_i,
	input wire logic phase_a_i,
	input wire logic phase_b_i,
	input wire logic idle_high_i,
	input wire logic [2:0] sel_a_i,
	input wire logic [2:0] sel_b_i,
	output logic [7:0] pins_o
);
	logic [7:0] noise_q;
	initial noise_q = 8'h5a;
	// Unused pins carry noise so a wrong selector shows
	always @(posedge sys_clk_i) begin
		noise_q <= {noise_q[6:0], noise_q[7] ^ noise_q[5] ^ noise_q[4] ^ noise_q[3]};
	end
	always_comb begin
		pins_o = noise_q;
		pins_o[sel_a_i] = phase_a_i ^ idle_high_i;
		pins_o[sel_b_i] = phase_b_i ^ idle_high_i;
	end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench of the wheel phase decoder
`timescale 1ns/100ps
`define CHK(nm, ex, gt) num_checks++; if ((gt) !== (ex)) begin errors++; $display("unexpected %s exp %h got %h", nm, ex, gt); end
module tb_top;
	localparam int unsigned SLOW = 4;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic blk = 1'b0;
	wheel_decoder_pkg::reg_req_s req = '0;
	logic [7:0] rdata;
	logic [7:0] pins;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic pol = 1'b0;
	logic [2:0] sa = 3'h0;
	logic [2:0] sb = 3'h1;
	int h = 64;
	int errors = 0;
	int num_checks = 0;
	always #25 sys_clk = ~sys_clk;
	wheel_phase_decoder #(.SLOW_DIV(SLOW), .DEB_SAMPLES(6)) dut_u (.sys_clk_i(sys_clk), .srst_i(srst),
		.block_reset_i(blk), .reg_req_i(req), .reg_rdata_o(rdata), .port_pins_i(pins));
	wheel_encoder_model enc_u (.sys_clk_i(sys_clk), .phase_a_i(pa), .phase_b_i(pb), .idle_high_i(pol),
		.sel_a_i(sa), .sel_b_i(sb), .pins_o(pins));
	function automatic wheel_decoder_pkg::reg_req_s wq(input logic [7:0] a, input logic [7:0] d);
		return '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
	endfunction
	function automatic wheel_decoder_pkg::reg_req_s rq(input logic [7:0] a);
		return '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
	endfunction
	function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'hd1: return d & 8'h37;
			8'hd2, 8'hd3: return d & 8'h07;
			8'hd6, 8'hd7: return d & 8'h01;
			default: return 8'h00;
		endcase
	endfunction
	task automatic bus(input wheel_decoder_pkg::reg_req_s r1, input wheel_decoder_pkg::reg_req_s r2,
		output logic [7:0] d1, output logic [7:0] d2);
		req <= r1;
		@(posedge sys_clk);
		req <= r2;
		#1 d1 = rdata;
		@(posedge sys_clk);
		req <= '0;
		#1 d2 = rdata;
		@(posedge sys_clk);
	endtask
	// Hold of h keeps levels and edge spacing legal
	task automatic mv(input logic ta, input logic tb);
		pa <= pa ^ ta;
		pb <= pb ^ tb;
		repeat (h) @(posedge sys_clk);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		final_report();
	end
	initial begin
		logic [7:0] d1, d2, a, d;
		logic [2:0] s, s2;
		logic dbl, shut, fwd;
		int n, k, ex;
		void'($urandom(32'h0000_e09e));
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		bus(rq(8'hd2), rq(8'hd3), d1, d2);
		`CHK("sel_a_rst", 8'h00, d1)
		`CHK("sel_b_rst", 8'h01, d2)
		for (int i = 0; i < 16; i++) begin
			a = 8'hd0 + 8'($urandom % 10);
			a = (a == 8'hd8) ? 8'hd9 : a;
			d = 8'($urandom);
			bus(wq(a, d), rq(a), d1, d2);
			`CHK("readback", exp_rd(a, d), d2)
		end
		for (int t = 0; t < 12; t++) begin
			n = $urandom % 3;
			h = (16 * SLOW) << n;
			shut = (t % 4 == 3);
			dbl = !shut && ($urandom % 2 == 1);
			fwd = shut || ($urandom % 2 == 1);
			k = 1 + $urandom % 5;
			s = 3'($urandom);
			s2 = s + 3'(1 + $urandom % 7);
			sa <= s;
			sb <= s2;
			pol <= 1'($urandom);
			pa <= 1'b0;
			pb <= 1'b0;
			@(posedge sys_clk);
			bus(wq(8'hd1, {2'b00, shut, pol, 1'b0, 3'(n)}), wq(8'hd2, {5'h00, s}), d1, d2);
			bus(wq(8'hd3, {5'h00, s2}), wq(8'hd7, {7'h00, dbl}), d1, d2);
			repeat (2 * h) @(posedge sys_clk);
			blk <= 1'b1;
			@(posedge sys_clk);
			bus(wq(8'hd8, 8'h01), rq(8'hd0), d1, d2);
			blk <= 1'b0;
			`CHK("blk_clear", 8'h00, d2)
			if (t % 2 == 1) begin
				// Pulse of two sample periods, well inside the window
				pa <= ~pa;
				repeat (2 * SLOW << n) @(posedge sys_clk);
				mv(1'b1, 1'b0);
			end
			for (int j = 0; j < k; j++) begin
				if (shut) begin
					mv(1'b1, 1'b0);
					mv(1'b1, 1'b0);
					mv(1'b0, 1'b1);
					mv(1'b0, 1'b1);
				end else if (fwd) begin
					mv(1'b1, 1'b0);
					mv(1'b0, 1'b1);
				end else begin
					mv(1'b0, 1'b1);
					mv(1'b1, 1'b0);
				end
			end
			bus(rq(8'hd0), wq(8'hd8, 8'h01), d1, d2);
			`CHK("no_auto", 8'h00, d1)
			bus(rq(8'hd0), rq(8'hd0), d1, d2);
			ex = (fwd ? k : -k) * (dbl ? 2 : 1);
			if (shut) begin
				`CHK("shuttle", 8'(k), d1)
			end else begin
				`CHK("count", 8'(ex), d1)
			end
			`CHK("cleared", 8'h00, d2)
			$display("test %0d done", t);
		end
		final_report();
	end
endmodule
